// *** core/rsa_params.svh ***
// Purpose: shared constants for the two-wire slave front end and its master
// Assumes: included by bare name from both ends
// Notes: the lockout count derives from the link clock rate; the clock half period count is a fixed value
`ifndef RSA_PARAMS_SVH
`define RSA_PARAMS_SVH
`define RSA_ID_ARRAY      4'ha
`define RSA_ID_CTRL       4'hd
`define RSA_DEV_SELECT    3'h7
`define RSA_BYTE_BITS     4'h8
`define RSA_ADDR_RESET    16'h0000
`define RSA_LOCKOUT_MS    90
`define RSA_LINK_NS       48
`define RSA_LOCKOUT_CYC   ((`RSA_LOCKOUT_MS * 1000000) / `RSA_LINK_NS)
`define RSA_CORE_HZ       20000000
`define RSA_SCL_HALF      16'h0004
`endif

// *** core/rsa_pkg.sv ***
// Purpose: types for the two-wire link; only the slave end uses them
// Assumes: constants live in rsa_params.svh
// Notes: none
package rsa_pkg;
	typedef enum logic [1:0] {RSA_TGT_NONE, RSA_TGT_ARRAY, RSA_TGT_CTRL} rsa_target_t;
	typedef enum logic [2:0] {RSA_S_IDLE, RSA_S_ADDR, RSA_S_ADDR_ACK, RSA_S_WR, RSA_S_WR_ACK,
		RSA_S_RD, RSA_S_RD_ACK} rsa_state_t;
endpackage

// *** core/rsa_bus_if.sv ***
// Purpose: two-wire bus carrier joining master and slave ends
// Assumes: open-drain lines, pull-up modelled by wired-and of enables
// Notes: a line is low when any party enables its driver low
`timescale 1ns/10ps
interface rsa_bus_if;
	logic scl_o;     // master clock drive level
	logic scl_oe;    // master clock enable
	logic sda_m_o;   // master data level
	logic sda_m_oe;  // master data enable
	logic sda_s_o;   // slave data level
	logic sda_s_oe;  // slave data enable
	logic scl;       // resolved clock line
	logic sda;       // resolved data line
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
	modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
	modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface // rsa_bus_if

// *** core/rsa_slave.sv ***
// Operation
// - data changes only while clock is low
// - ignore everything until a start condition
// - stop ends transaction, enters standby
// - master stops only after line released
// - ninth clock carries receiver acknowledge low
// - no acknowledge on address mismatch
// - acknowledge every written byte
// - read continues only on acknowledge
// - master stops after final non-acknowledge
// - upper nibble selects array or control
// - device select bits fixed at 111
// - lowest address bit chooses read/write
// - acknowledge only exact seven-bit match
// - two-byte word address follows slave byte
// - address counter zero at power-up
// - master repeats same target in random read
// - brownout locks bus out about 90ms
// - switchover mode bit, legacy default
// - backup bus disable governs backup operation
// - disable bit one turns bus off
// - no array acknowledge during write cycle
// Purpose: slave end of the two-wire link, address decode and acknowledge
// Assumes: runs on link_clk, oversampling scl and sda through two flops
// Notes: data bytes go to/from the user side; memory itself lives outside
`timescale 1ns/10ps
`include "rsa_params.svh"
module rsa_slave #(
	parameter int unsigned LOCKOUT_CYC = `RSA_LOCKOUT_CYC  // lockout length in link cycles
) (
	input  wire logic     link_clk,            // link-side sampling clock
	input  wire logic     reset,               // async, active high
	rsa_bus_if.slave      bus,                 // two-wire bus
	input  wire logic     brownout_glitch,     // qualifying power-up glitch, async level
	input  wire logic     on_backup,           // running from backup supply, async level
	input  wire logic     backup_bus_disable,  // 1: bus off in backup
	input  wire logic     switchover_mode_select, // 0 standard, 1 legacy
	input  wire logic     nv_write_busy,       // internal write cycle running
	input  wire logic [7:0] rd_data,           // byte to send on reads
	output logic          rd_take,             // pulse: rd_data consumed
	output logic [7:0]    wr_data,             // last received data byte
	output logic          wr_valid,            // pulse: wr_data new
	output logic [15:0]   word_addr,           // current word address
	output logic          target_ctrl,         // 1: control block selected
	output logic          use_legacy_switch,   // switchover policy in force
	output logic          bus_locked           // lockout or backup disable active
);
	logic [1:0]  scl_s_r, sda_s_r, bo_s_r, bk_s_r, bd_s_r, nb_s_r;
	logic        scl_d_r, sda_d_r;
	logic [31:0] lock_cnt_r;
	rsa_pkg::rsa_state_t st_r;
	logic [3:0]  bit_cnt_r;
	logic [7:0]  sh_r;
	logic [1:0]  addr_bytes_r;
	logic        rw_r, drive_low_r;
	logic [7:0]  tx_r;
	logic        bo_d_r;

	wire scl_rise  = scl_s_r[1] && !scl_d_r;
	wire scl_fall  = !scl_s_r[1] && scl_d_r;
	wire start_det = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
	wire stop_det  = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
	wire lock_bo   = lock_cnt_r != 32'h0;
	wire lock_bk   = bk_s_r[1] && bd_s_r[1];
	wire locked    = lock_bo || lock_bk;
	wire [7:0] sh_in = {sh_r[6:0], sda_s_r[1]};
	wire id_array  = sh_in[7:4] == `RSA_ID_ARRAY;
	wire id_ctrl   = sh_in[7:4] == `RSA_ID_CTRL;
	wire sel_ok    = sh_in[3:1] == `RSA_DEV_SELECT;
	wire addr_hit  = sel_ok && (id_ctrl || (id_array && !nb_s_r[1]));
	wire byte_done = scl_rise && bit_cnt_r == `RSA_BYTE_BITS - 4'h1;

	assign bus.sda_s_o      = 1'b0;
	assign bus.sda_s_oe     = drive_low_r && !locked;
	assign use_legacy_switch = switchover_mode_select;
	assign bus_locked       = locked;

	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			bo_s_r  <= 2'h0;
			bk_s_r  <= 2'h0;
			bd_s_r  <= 2'h0;
			nb_s_r  <= 2'h0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			bo_d_r  <= 1'b0;
		end else begin
			scl_s_r <= {scl_s_r[0], bus.scl};
			sda_s_r <= {sda_s_r[0], bus.sda};
			bo_s_r  <= {bo_s_r[0], brownout_glitch};
			bk_s_r  <= {bk_s_r[0], on_backup};
			// control levels arrive from the core side, so they cross through two flops too
			bd_s_r  <= {bd_s_r[0], backup_bus_disable};
			nb_s_r  <= {nb_s_r[0], nv_write_busy};
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
			bo_d_r  <= bo_s_r[1];
		end
	end

	// restart on every new glitch edge; a held level does not extend it
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset)
			lock_cnt_r <= 32'h0;
		else if (bo_s_r[1] && !bo_d_r)
			lock_cnt_r <= 32'(LOCKOUT_CYC);
		else if (lock_bo)
			lock_cnt_r <= lock_cnt_r - 32'h1;
	end

	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			st_r         <= rsa_pkg::RSA_S_IDLE;
			bit_cnt_r    <= 4'h0;
			sh_r         <= 8'h00;
			addr_bytes_r <= 2'h0;
			rw_r         <= 1'b0;
			drive_low_r  <= 1'b0;
			tx_r         <= 8'h00;
			word_addr    <= `RSA_ADDR_RESET;
			target_ctrl  <= 1'b0;
			wr_data      <= 8'h00;
			wr_valid     <= 1'b0;
			rd_take      <= 1'b0;
		end else begin
			wr_valid <= 1'b0;
			rd_take  <= 1'b0;
			if (locked || stop_det) begin
				st_r        <= rsa_pkg::RSA_S_IDLE;
				drive_low_r <= 1'b0;
			end else if (start_det) begin
				st_r        <= rsa_pkg::RSA_S_ADDR;
				bit_cnt_r   <= 4'h0;
				drive_low_r <= 1'b0;
			end else begin
				unique case (st_r)
				rsa_pkg::RSA_S_IDLE: ;
				rsa_pkg::RSA_S_ADDR, rsa_pkg::RSA_S_WR: begin
					if (scl_rise) begin
						sh_r      <= sh_in;
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					if (byte_done && st_r == rsa_pkg::RSA_S_ADDR) begin
						if (addr_hit) begin
							st_r         <= rsa_pkg::RSA_S_ADDR_ACK;
							rw_r         <= sh_in[0];
							target_ctrl  <= id_ctrl;
							addr_bytes_r <= 2'h0;
						end else
							st_r <= rsa_pkg::RSA_S_IDLE;
					end else if (byte_done) begin
						st_r <= rsa_pkg::RSA_S_WR_ACK;
						if (addr_bytes_r != 2'h2) begin
							word_addr    <= {word_addr[7:0], sh_in};
							addr_bytes_r <= addr_bytes_r + 2'h1;
						end else begin
							wr_data   <= sh_in;
							wr_valid  <= 1'b1;
							word_addr <= word_addr + 16'h1;
						end
					end
				end
				rsa_pkg::RSA_S_ADDR_ACK, rsa_pkg::RSA_S_WR_ACK: begin
					if (scl_fall && !drive_low_r)
						drive_low_r <= 1'b1;
					else if (scl_fall) begin
						drive_low_r <= 1'b0;
						bit_cnt_r   <= 4'h0;
						if (rw_r) begin
							st_r        <= rsa_pkg::RSA_S_RD;
							tx_r        <= rd_data;
							rd_take     <= 1'b1;
							word_addr   <= word_addr + 16'h1;
							drive_low_r <= !rd_data[7];
						end else
							st_r <= rsa_pkg::RSA_S_WR;
					end
				end
				rsa_pkg::RSA_S_RD: begin
					if (scl_fall) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
						tx_r      <= {tx_r[6:0], 1'b1};
						if (bit_cnt_r == `RSA_BYTE_BITS - 4'h1) begin
							drive_low_r <= 1'b0;
							st_r        <= rsa_pkg::RSA_S_RD_ACK;
						end else
							drive_low_r <= !tx_r[6];
					end
				end
				rsa_pkg::RSA_S_RD_ACK: begin
					if (scl_rise)
						rw_r <= !sda_s_r[1];
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (rw_r) begin
							st_r        <= rsa_pkg::RSA_S_RD;
							tx_r        <= rd_data;
							rd_take     <= 1'b1;
							word_addr   <= word_addr + 16'h1;
							drive_low_r <= !rd_data[7];
						end else
							st_r <= rsa_pkg::RSA_S_IDLE;
					end
				end
				default: st_r <= rsa_pkg::RSA_S_IDLE;
				endcase
			end
		end
	end
endmodule // rsa_slave

// *** core/rsa_master.sv ***
// Purpose: master end that makes the link clock and runs single-byte transfers
// Assumes: core_clk domain; user request is a one-cycle pulse
// Notes: one byte per request; start, write byte, read byte, and stop are separate commands, ack bit rides with each byte
`timescale 1ns/10ps
`include "rsa_params.svh"
module rsa_master (
	input  wire logic       core_clk,  // core clock, 20 MHz
	input  wire logic       reset,     // async, active high
	rsa_bus_if.master       bus,       // two-wire bus
	input  wire logic       cmd_valid, // pulse: command request
	input  wire logic [1:0] cmd_op,    // 0 start, 1 write byte, 2 read byte, 3 stop
	input  wire logic       cmd_ack,   // read: drive ack low when 1
	input  wire logic [7:0] cmd_data,  // write byte
	output logic            busy,      // command in progress
	output logic            done,      // pulse: command finished
	output logic [7:0]      rx_data,   // byte read
	output logic            rx_ack     // acknowledge seen on write
);
	logic [15:0] div_r;
	logic [1:0]  ph_r;
	logic [3:0]  bit_r;
	logic [1:0]  op_r;
	logic [8:0]  sh_r;
	logic        scl_r, sda_r;
	logic [1:0]  sda_s_r;
	wire tick = div_r == 16'h0;

	assign bus.scl_o    = 1'b0;
	assign bus.scl_oe   = !scl_r;
	assign bus.sda_m_o  = 1'b0;
	assign bus.sda_m_oe = !sda_r;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			sda_s_r <= 2'h3;
		else
			sda_s_r <= {sda_s_r[0], bus.sda};
	end

	// four phases per bit: data set with clock low clock high, sample, clock low
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			div_r <= 16'h0;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			op_r <= 2'h0;
			sh_r <= 9'h1ff;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			busy <= 1'b0;
			done <= 1'b0;
			rx_data <= 8'h00;
			rx_ack <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (cmd_valid) begin
					busy  <= 1'b1;
					op_r  <= cmd_op;
					ph_r  <= 2'h0;
					bit_r <= 4'h0;
					div_r <= `RSA_SCL_HALF;
					sh_r  <= (cmd_op == 2'h2) ? {8'hff, !cmd_ack} : {cmd_data, 1'b1};
				end
			end else if (!tick)
				div_r <= div_r - 16'h1;
			else begin
				div_r <= `RSA_SCL_HALF;
				ph_r  <= ph_r + 2'h1;
				unique case (ph_r)
				2'h0: begin
					if (op_r == 2'h0)
						sda_r <= 1'b1;
					else if (op_r == 2'h3)
						sda_r <= 1'b0;
					else
						sda_r <= sh_r[8];
				end
				2'h1: scl_r <= 1'b1;
				2'h2: begin
					if (op_r == 2'h0)
						sda_r <= 1'b0;
					else if (op_r == 2'h3)
						sda_r <= 1'b1;
					else begin
						sh_r <= {sh_r[7:0], 1'b1};
						if (bit_r < 4'h8)
							rx_data <= {rx_data[6:0], sda_s_r[1]};
						else
							rx_ack <= !sda_s_r[1];
					end
				end
				2'h3: begin
					if (op_r == 2'h1 || op_r == 2'h2) begin
						scl_r <= 1'b0;
						bit_r <= bit_r + 4'h1;
						if (bit_r == 4'h8) begin
							busy <= 1'b0;
							done <= 1'b1;
						end
					end else begin
						if (op_r == 2'h0)
							scl_r <= 1'b0;
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
				endcase
			end
		end
	end
endmodule // rsa_master

// *** tb/rsa_bus_sva.sv ***
// Purpose: bus-level checks on the link joining master and slave
// Assumes: open-drain lines, slave pulls low only through sda_s_oe
// Notes: slave side sampled on link_clk, master clock edges on core_clk
`timescale 1ns/10ps
module rsa_bus_sva (
	input wire logic link_clk,   // slave clock
	input wire logic core_clk,   // master clock
	input wire logic reset,      // async, active high
	input wire logic scl,        // resolved clock line
	input wire logic sda,        // resolved data line
	input wire logic sda_s_o,    // slave data level
	input wire logic sda_s_oe,   // slave data enable
	input wire logic bus_locked  // slave lockout
);
	logic sda_d_r;
	logic in_frame_r;
	wire  s_low   = sda_s_oe && !sda_s_o;
	wire  start_w = scl && sda_d_r && !sda;
	wire  stop_w  = scl && !sda_d_r && sda;
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			sda_d_r    <= 1'b1;
			in_frame_r <= 1'b0;
		end else begin
			sda_d_r    <= sda;
			in_frame_r <= start_w || (in_frame_r && !stop_w);
		end
	end
	property p_frame;
		@(posedge link_clk) disable iff (reset) s_low |-> in_frame_r;
	endproperty
	a_frame: assert property (p_frame) else $error("slave drove outside a frame");
	property p_stop;
		@(posedge link_clk) disable iff (reset) stop_w |-> (!s_low) [*8];
	endproperty
	a_stop: assert property (p_stop) else $error("slave drove after stop");
	property p_rise;
		@(posedge link_clk) disable iff (reset) $rose(s_low) |-> !scl;
	endproperty
	a_rise: assert property (p_rise) else $error("slave pulled low with clock high");
	property p_fall;
		@(posedge link_clk) disable iff (reset) $fell(s_low) |-> !scl;
	endproperty
	a_fall: assert property (p_fall) else $error("slave released with clock high");
	property p_hold;
		@(posedge link_clk) disable iff (reset) s_low && scl |=> s_low || !scl;
	endproperty
	a_hold: assert property (p_hold) else $error("slave low cut short in clock high");
	property p_len;
		@(posedge link_clk) disable iff (reset) $rose(s_low) |-> s_low [*8];
	endproperty
	a_len: assert property (p_len) else $error("slave low too short for a bit");
	property p_lock;
		@(posedge link_clk) disable iff (reset) bus_locked |=> !sda_s_oe;
	endproperty
	a_lock: assert property (p_lock) else $error("slave drove while locked");
	property p_scl;
		@(posedge core_clk) disable iff (reset) $changed(scl) |-> $stable(sda);
	endproperty
	a_scl: assert property (p_scl) else $error("data moved with clock edge");
	c_start: cover property (@(posedge link_clk) disable iff (reset) start_w);
	c_stop: cover property (@(posedge link_clk) disable iff (reset) stop_w);
	c_ack: cover property (@(posedge link_clk) disable iff (reset) $rose(s_low));
endmodule // rsa_bus_sva

// *** tb/testbench.sv ***
// Purpose: drives the master end against the slave end over the bus
// Assumes: lockout shortened to 50 link cycles
// Notes: results checked from queues filled by the driver
`timescale 1ns/10ps
module testbench;
	logic       core_clk  = 0;
	logic       link_clk  = 0;
	logic       reset     = 1;
	logic       cmd_valid = 0;
	logic       cmd_ack   = 0;
	logic [1:0] cmd_op    = 0;
	logic [7:0] cmd_data  = 0;
	logic       glitch    = 0;
	logic       on_bk     = 0;
	logic       bk_dis    = 0;
	logic       sw_sel    = 1;
	logic       nv_busy   = 0;
	logic [7:0] rd_data   = 0;
	logic       done, rx_ack, wr_valid, use_legacy_switch, bus_locked, rd_take, tgt;
	logic [7:0] rx_data, wr_data, b;
	logic [15:0] word_addr;
	logic [9:0] ent;
	logic [9:0] q[$];
	logic [7:0] wq[$];
	logic [7:0] tbl[5] = '{8'hae, 8'hde, 8'ha6, 8'h5e, 8'hac};
	int         error_cnt = 0;
	int         n_checks  = 0;
	int         cyc       = 0;
	int         seed      = 32'h41e66e8a;
	int         i;
	int         n_rd      = 0;
	rsa_bus_if bif ();
	rsa_master u_rsa_master (.core_clk(core_clk), .reset(reset), .bus(bif),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ack(cmd_ack), .cmd_data(cmd_data),
		.busy(), .done(done), .rx_data(rx_data), .rx_ack(rx_ack));
	rsa_slave #(.LOCKOUT_CYC(50)) u_rsa_slave (.link_clk(link_clk), .reset(reset), .bus(bif),
		.brownout_glitch(glitch), .on_backup(on_bk), .backup_bus_disable(bk_dis),
		.switchover_mode_select(sw_sel), .nv_write_busy(nv_busy), .rd_data(rd_data),
		.rd_take(rd_take), .wr_data(wr_data), .wr_valid(wr_valid), .word_addr(word_addr),
		.target_ctrl(tgt), .use_legacy_switch(use_legacy_switch), .bus_locked(bus_locked));
	rsa_bus_sva u_rsa_bus_sva (.link_clk(link_clk), .core_clk(core_clk), .reset(reset),
		.scl(bif.scl), .sda(bif.sda), .sda_s_o(bif.sda_s_o), .sda_s_oe(bif.sda_s_oe),
		.bus_locked(bus_locked));
	always #25 core_clk = ~core_clk;
	// odd start offset keeps the two clocks out of phase
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmd(input logic [1:0] op, input logic a, input logic [7:0] d,
		input logic [9:0] e);
		q.push_back(e);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_op    <= op;
		cmd_ack   <= a;
		cmd_data  <= d;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		while (done !== 1'b1) @(posedge core_clk);
	endtask
	task automatic start;
		cmd(2'h0, 1'b0, 8'h00, 10'h000);
	endtask
	task automatic stop;
		cmd(2'h3, 1'b0, 8'h00, 10'h000);
	endtask
	task automatic wb(input logic [7:0] d, input logic ea);
		cmd(2'h1, 1'b0, d, {2'h1, 7'h00, ea});
	endtask
	task automatic rd(input logic a);
		cmd(2'h2, a, 8'h00, {2'h2, rd_data});
	endtask
	task automatic adr(input logic [7:0] d, input logic ea);
		start;
		wb(d, ea);
		stop;
	endtask
	always @(posedge core_clk) begin
		if (done === 1'b1) begin
			ent = q.pop_front();
			if (ent[9:8] == 2'h1) chk("rx_ack", ent[0], rx_ack);
			if (ent[9:8] == 2'h2) chk("rx_data", ent[7:0], rx_data);
		end
	end
	always @(posedge link_clk) begin
		if (wr_valid === 1'b1) chk("wr_data", wq.pop_front(), wr_data);
		if (rd_take === 1'b1) n_rd++;
	end
	// ceiling well above the roughly 6000 cycles the sequence needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test;
		end
	end
	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rd_data <= 8'($random(seed));
		chk("word_addr", 16'h0000, word_addr);
		start;
		wb(8'haf, 1'b1);
		rd(1'b1);
		rd(1'b0);
		stop;
		chk("word_addr", 16'h0002, word_addr);
		$display("test read done");
		for (i = 0; i < 9; i++) begin
			b = (i < 5) ? tbl[i] : (8'($random(seed)) & 8'hfe);
			adr(b, b[7:1] == 7'h57 || b[7:1] == 7'h6f);
		end
		$display("test decode done");
		start;
		wb(8'hae, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h05, 1'b1);
		repeat (2) begin
			b = 8'($random(seed));
			wq.push_back(b);
			wb(b, 1'b1);
		end
		stop;
		chk("word_addr", 16'h0007, word_addr);
		chk("wr_left", 16'h0000, 16'(wq.size()));
		$display("test write done");
		start;
		wb(8'hae, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h03, 1'b1);
		start;
		wb(8'haf, 1'b1);
		rd(1'b0);
		stop;
		chk("word_addr", 16'h0004, word_addr);
		chk("rd_take", 16'h0003, 16'(n_rd));
		$display("test random read done");
		@(posedge core_clk) nv_busy <= 1'b1;
		adr(8'hae, 1'b0);
		adr(8'hde, 1'b1);
		chk("target_ctrl", 16'h0001, {15'h0000, tgt});
		nv_busy <= 1'b0;
		@(posedge core_clk) glitch <= 1'b1;
		adr(8'hae, 1'b0);
		glitch <= 1'b0;
		adr(8'hae, 1'b1);
		chk("target_ctrl", 16'h0000, {15'h0000, tgt});
		@(posedge core_clk) on_bk <= 1'b1;
		bk_dis <= 1'b1;
		adr(8'hae, 1'b0);
		chk("bus_locked", 16'h0001, {15'h0000, bus_locked});
		bk_dis <= 1'b0;
		adr(8'hae, 1'b1);
		on_bk <= 1'b0;
		$display("test lockout done");
		for (i = 0; i < 2; i++) begin
			@(posedge core_clk) sw_sel <= i[0];
			@(posedge core_clk) chk("legacy", {15'h0000, i[0]}, {15'h0000, use_legacy_switch});
		end
		$display("test switchover done");
		end_of_test;
	end
endmodule // testbench
